// File: hdl/fpe_pkg.sv
// Constants for the flash program/erase sequencer: APB map, control
// fields, reset values, flash geometry, operation timing and states.
// Assumes a 10 MHz system clock.
package fpe_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFS_PS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FLASH_CTRL  = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;

  // program_store_control_reg fields
  localparam int PS_WRITE_EN_BIT   = 0;
  localparam int PS_ERASE_EN_BIT   = 1;
  localparam int PS_SCRATCH_BIT    = 2;
  localparam logic [7:0] PS_CTRL_RESET    = 8'h00;

  // flash_control_reg fields
  localparam int FL_SW_WRITE_EN_BIT = 0;
  localparam int FL_READ_ALWAYS_BIT = 6;
  localparam int FL_ONE_SHOT_BIT    = 7;
  localparam logic [7:0] FL_CTRL_RESET    = 8'h80;

  // status register fields
  localparam int ST_BUSY_BIT        = 0;
  localparam int ST_REFUSED_BIT     = 1;

  // Flash geometry
  localparam int          MAIN_BYTES      = 65536;
  localparam int          SCRATCH_BYTES   = 128;
  localparam logic [15:0] PAGE_BYTES      = 16'h0200;
  localparam logic [15:0] SCRATCH_LIMIT   = 16'h0080;
  localparam logic [15:0] RESERVED_BASE   = 16'hfe00;
  localparam logic [15:0] READ_LOCK_ADDR  = 16'hfdff;
  localparam logic [15:0] WRITE_LOCK_ADDR = 16'hfdfe;
  localparam logic [6:0]  LOCK_PAGE       = 7'h7e;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  localparam logic [7:0]  DENIED_BYTE     = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int WRITE_TIME_US   = 50;
  localparam int ERASE_TIME_MS   = 12;
  localparam int WRITE_CYCLES    = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // JTAG operation codes
  localparam logic [1:0] JOP_READ  = 2'h0;
  localparam logic [1:0] JOP_WRITE = 2'h1;
  localparam logic [1:0] JOP_ERASE = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_ERASE
  } fpe_state_type;

endpackage : fpe_pkg

// File: hdl/fpe_flash_ctrl.sv
// Flash program/erase sequencer with APB control registers, CPU
// data-space write redirection, JTAG access port and the flash array.
// Assumes CPU and JTAG request ports come from logic on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module fpe_flash_ctrl
  import fpe_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  // CPU data-space accesses
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic             cpu_stall_o,
  output logic             irq_hold_o,
  // External data RAM side
  output logic             external_data_ram_we_o,
  output logic             external_data_ram_re_o,
  output logic [15:0]      external_data_ram_addr_o,
  output logic [7:0]       external_data_ram_wdata_o,
  // CPU code-space reads
  input  wire logic [15:0] code_addr_i,
  input  wire logic        code_fetch_i,
  output logic [7:0]       code_rdata_o,
  // JTAG flash port
  input  wire logic        jtag_req_i,
  input  wire logic [1:0]  jtag_op_i,
  input  wire logic [15:0] jtag_addr_i,
  input  wire logic [7:0]  jtag_wdata_i,
  output logic             jtag_done_o,
  output logic             jtag_denied_o,
  output logic [7:0]       jtag_rdata_o,
  output logic [7:0]       jtag_debug_lock_o
);

  localparam logic [19:0] WRITE_LOAD = 20'(WRITE_CYCLES - 1);
  localparam logic [19:0] ERASE_LOAD = 20'(ERASE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////
  // Flash array
  logic [7:0]  main_mem    [0:MAIN_BYTES-1];
  logic [7:0]  scratch_mem [0:SCRATCH_BYTES-1];
  logic        mem_we;
  logic        mem_scratch;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  read_lock;
  logic [7:0]  write_lock;

  // A fresh part arrives erased; contents survive reset
  initial begin
    for (int i = 0; i < MAIN_BYTES; i++) begin
      main_mem[i] = ERASED_BYTE;
    end
    for (int i = 0; i < SCRATCH_BYTES; i++) begin
      scratch_mem[i] = ERASED_BYTE;
    end
  end

  // Plain always, since the erased preset above also writes the array
  always @(posedge sys_clk_i) begin
    if (mem_we && mem_scratch) begin
      scratch_mem[mem_addr[6:0]] <= mem_wdata;
    end else if (mem_we) begin
      main_mem[mem_addr] <= mem_wdata;
    end
  end

  assign read_lock  = main_mem[READ_LOCK_ADDR];
  assign write_lock = main_mem[WRITE_LOCK_ADDR];

  ////////////////////////////////////////////////////////////////////
  // Registers and sequencer state
  fpe_state_type state_reg, state_next;
  logic [19:0] timer_reg, timer_next;
  logic [9:0]  sweep_reg, sweep_next;
  logic [15:0] base_reg, base_next;
  logic        scratch_op_reg, scratch_op_next;
  logic        jtag_op_reg, jtag_op_next;
  logic [7:0]  ps_ctrl_reg, ps_ctrl_next;
  logic [7:0]  fl_ctrl_reg, fl_ctrl_next;
  logic        refused_reg, refused_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        stall_reg, stall_next;
  logic        xwe_reg, xwe_next;
  logic        xre_reg, xre_next;
  logic [15:0] xaddr_reg, xaddr_next;
  logic [7:0]  xwdata_reg, xwdata_next;
  logic [7:0]  code_rdata_reg, code_rdata_next;
  logic        jdone_reg, jdone_next;
  logic        jdenied_reg, jdenied_next;
  logic [7:0]  jrdata_reg, jrdata_next;
  logic [7:0]  jdbg_reg, jdbg_next;

  logic        apb_access;
  logic        apb_write;
  logic        refuse_evt;
  logic        program_store_write_enable;
  logic        program_store_erase_enable;
  logic        scratchpad_select;
  logic        flash_software_write_enable;
  logic        cpu_scratch;
  logic        jtag_take;
  logic        sweep_last;
  logic        lock_addr;

  assign program_store_write_enable = ps_ctrl_reg[PS_WRITE_EN_BIT];
  assign program_store_erase_enable = ps_ctrl_reg[PS_ERASE_EN_BIT];
  assign scratchpad_select = ps_ctrl_reg[PS_SCRATCH_BIT];
  assign flash_software_write_enable = fl_ctrl_reg[FL_SW_WRITE_EN_BIT];

  assign apb_access  = psel_i && penable_i && pready_reg;
  assign apb_write   = apb_access && pwrite_i;
  assign cpu_scratch = scratchpad_select && (cpu_addr_i < SCRATCH_LIMIT);
  assign jtag_take   = jtag_req_i && !jdone_reg && !cpu_wr_i;
  assign lock_addr   = (jtag_addr_i == READ_LOCK_ADDR) || (jtag_addr_i == WRITE_LOCK_ADDR);
  assign sweep_last  = scratch_op_reg ? (sweep_reg == 10'(SCRATCH_LIMIT - 16'h0001))
                                      : (sweep_reg == 10'(PAGE_BYTES - 16'h0001));

  ////////////////////////////////////////////////////////////////////
  // Sequencer and access decode
  always_comb begin
    state_next      = state_reg;
    timer_next      = timer_reg;
    sweep_next      = sweep_reg;
    base_next       = base_reg;
    scratch_op_next = scratch_op_reg;
    jtag_op_next    = jtag_op_reg;
    refuse_evt      = 1'b0;
    mem_we          = 1'b0;
    mem_scratch     = 1'b0;
    mem_addr        = cpu_addr_i;
    mem_wdata       = cpu_wdata_i;
    xwe_next        = 1'b0;
    xre_next        = cpu_rd_i;
    xaddr_next      = cpu_addr_i;
    xwdata_next     = cpu_wdata_i;
    jdone_next      = 1'b0;
    jdenied_next    = 1'b0;
    jrdata_next     = jrdata_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cpu_wr_i) begin
          if (!program_store_write_enable) begin
            xwe_next = 1'b1;
          end else if (!flash_software_write_enable) begin
            refuse_evt = 1'b1;
          end else if (!cpu_scratch && (cpu_addr_i >= RESERVED_BASE)) begin
            refuse_evt = 1'b1;
          end else if (program_store_erase_enable) begin
            if (!cpu_scratch && (cpu_addr_i[15:9] == LOCK_PAGE)) begin
              refuse_evt = 1'b1;
            end else begin
              state_next      = ST_ERASE;
              timer_next      = ERASE_LOAD;
              sweep_next      = '0;
              scratch_op_next = cpu_scratch;
              base_next       = cpu_scratch ? 16'h0000 : {cpu_addr_i[15:9], 9'h000};
              jtag_op_next    = 1'b0;
            end
          end else begin
            state_next   = ST_PROG;
            timer_next   = WRITE_LOAD;
            jtag_op_next = 1'b0;
            mem_we       = 1'b1;
            mem_scratch  = cpu_scratch;
            mem_wdata    = cpu_wdata_i & (cpu_scratch ? scratch_mem[cpu_addr_i[6:0]]
                                                      : main_mem[cpu_addr_i]);
          end
        end else if (jtag_take) begin
          mem_addr  = jtag_addr_i;
          mem_wdata = jtag_wdata_i & main_mem[jtag_addr_i];
          if (jtag_addr_i >= RESERVED_BASE) begin
            jrdata_next  = DENIED_BYTE;
            jdone_next   = 1'b1;
            jdenied_next = 1'b1;
          end else if (jtag_op_i == JOP_READ) begin
            jdone_next = 1'b1;
            if (!lock_addr && !read_lock[jtag_addr_i[15:13]]) begin
              jdenied_next = 1'b1;
              jrdata_next  = DENIED_BYTE;
            end else begin
              jrdata_next = main_mem[jtag_addr_i];
            end
          end else if (jtag_op_i == JOP_WRITE) begin
            if (!lock_addr && !write_lock[jtag_addr_i[15:13]]) begin
              jdone_next   = 1'b1;
              jdenied_next = 1'b1;
            end else begin
              state_next   = ST_PROG;
              timer_next   = WRITE_LOAD;
              jtag_op_next = 1'b1;
              mem_we       = 1'b1;
            end
          end else if (jtag_op_i == JOP_ERASE) begin
            if (!write_lock[jtag_addr_i[15:13]]) begin
              jdone_next   = 1'b1;
              jdenied_next = 1'b1;
            end else begin
              state_next      = ST_ERASE;
              timer_next      = ERASE_LOAD;
              sweep_next      = '0;
              scratch_op_next = 1'b0;
              base_next       = {jtag_addr_i[15:9], 9'h000};
              jtag_op_next    = 1'b1;
            end
          end else begin
            jdone_next   = 1'b1;
            jdenied_next = 1'b1;
          end
        end
      end
      ST_PROG: begin
        // Byte already stored; the timer models the cell write time
        if (timer_reg == '0) begin
          state_next = ST_IDLE;
          jdone_next = jtag_op_reg;
        end else begin
          timer_next = timer_reg - 20'h00001;
        end
      end
      ST_ERASE: begin
        // One byte per cycle; a shortened timer still waits for the sweep
        mem_we      = !(sweep_last && (sweep_reg == 10'h3ff));
        mem_scratch = scratch_op_reg;
        mem_addr    = base_reg | {6'h00, sweep_reg};
        mem_wdata   = ERASED_BYTE;
        if (!sweep_last) begin
          sweep_next = sweep_reg + 10'h001;
        end
        if (timer_reg != '0) begin
          timer_next = timer_reg - 20'h00001;
        end else if (sweep_last) begin
          state_next = ST_IDLE;
          jdone_next = jtag_op_reg;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    stall_next = (state_next != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////
  // APB register file
  always_comb begin
    ps_ctrl_next = ps_ctrl_reg;
    fl_ctrl_next = fl_ctrl_reg;
    refused_next = refused_reg;
    pready_next  = psel_i && penable_i && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next  = '0;
    // Only a software write touches the enables; completions never do
    if (apb_write && (paddr_i == OFS_PS_CTRL)) begin
      ps_ctrl_next = {5'h00, pwdata_i[2:0]};
    end
    if (apb_write && (paddr_i == OFS_FLASH_CTRL)) begin
      fl_ctrl_next = {pwdata_i[7:6], 5'h00, pwdata_i[0]};
    end
    if (apb_write && (paddr_i == OFS_STATUS) && pwdata_i[ST_REFUSED_BIT]) begin
      refused_next = 1'b0;
    end
    // A refusal in the clearing cycle wins
    if (refuse_evt) begin
      refused_next = 1'b1;
    end
    if (pready_next && !pwrite_i) begin
      case (paddr_i)
        OFS_PS_CTRL:    prdata_next = {24'h000000, ps_ctrl_reg};
        OFS_FLASH_CTRL: prdata_next = {24'h000000, fl_ctrl_reg};
        OFS_STATUS:     prdata_next = {30'h00000000, refused_reg, stall_reg};
        default:        prdata_next = '0;
      endcase
    end
    if (pready_next) begin
      pslverr_next = !((paddr_i == OFS_PS_CTRL) || (paddr_i == OFS_FLASH_CTRL) ||
                       (paddr_i == OFS_STATUS));
    end
    // Fetches never see the scratchpad, only table reads do
    code_rdata_next = (!code_fetch_i && scratchpad_select && (code_addr_i < SCRATCH_LIMIT))
                    ? scratch_mem[code_addr_i[6:0]] : main_mem[code_addr_i];
    jdbg_next = ~read_lock;
  end

  ////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg      <= ST_IDLE;
      timer_reg      <= '0;
      sweep_reg      <= '0;
      base_reg       <= '0;
      scratch_op_reg <= 1'b0;
      jtag_op_reg    <= 1'b0;
      ps_ctrl_reg    <= PS_CTRL_RESET;
      fl_ctrl_reg    <= FL_CTRL_RESET;
      refused_reg    <= 1'b0;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      prdata_reg     <= '0;
      stall_reg      <= 1'b0;
      xwe_reg        <= 1'b0;
      xre_reg        <= 1'b0;
      xaddr_reg      <= '0;
      xwdata_reg     <= '0;
      code_rdata_reg <= '0;
      jdone_reg      <= 1'b0;
      jdenied_reg    <= 1'b0;
      jrdata_reg     <= '0;
      jdbg_reg       <= '0;
    end else begin
      state_reg      <= state_next;
      timer_reg      <= timer_next;
      sweep_reg      <= sweep_next;
      base_reg       <= base_next;
      scratch_op_reg <= scratch_op_next;
      jtag_op_reg    <= jtag_op_next;
      ps_ctrl_reg    <= ps_ctrl_next;
      fl_ctrl_reg    <= fl_ctrl_next;
      refused_reg    <= refused_next;
      pready_reg     <= pready_next;
      pslverr_reg    <= pslverr_next;
      prdata_reg     <= prdata_next;
      stall_reg      <= stall_next;
      xwe_reg        <= xwe_next;
      xre_reg        <= xre_next;
      xaddr_reg      <= xaddr_next;
      xwdata_reg     <= xwdata_next;
      code_rdata_reg <= code_rdata_next;
      jdone_reg      <= jdone_next;
      jdenied_reg    <= jdenied_next;
      jrdata_reg     <= jrdata_next;
      jdbg_reg       <= jdbg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready_o                  = pready_reg;
  assign pslverr_o                 = pslverr_reg;
  assign prdata_o                  = prdata_reg;
  assign cpu_stall_o               = stall_reg;
  assign irq_hold_o                = stall_reg;
  assign external_data_ram_we_o    = xwe_reg;
  assign external_data_ram_re_o    = xre_reg;
  assign external_data_ram_addr_o  = xaddr_reg;
  assign external_data_ram_wdata_o = xwdata_reg;
  assign code_rdata_o              = code_rdata_reg;
  assign jtag_done_o               = jdone_reg;
  assign jtag_denied_o             = jdenied_reg;
  assign jtag_rdata_o              = jrdata_reg;
  assign jtag_debug_lock_o         = jdbg_reg;

endmodule : fpe_flash_ctrl

`default_nettype wire

// File: dv/fpe_flash_ctrl_asserts.sv
// Concurrent checks on the flash sequencer top ports.
// Assumes ERASE_CYCLES of at least 512, so every erase stall lasts ERASE_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_ctrl_asserts
  import fpe_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        cpu_wr_i,
  input wire logic        cpu_rd_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic        cpu_stall_o,
  input wire logic        irq_hold_o,
  input wire logic        external_data_ram_we_o,
  input wire logic        external_data_ram_re_o,
  input wire logic        jtag_done_o,
  input wire logic [1:0]  jtag_op_i,
  input wire logic        jtag_denied_o,
  input wire logic [7:0]  jtag_rdata_o
);
  logic        program_store_write_enable_reg, program_store_write_enable_next, program_store_erase_enable_reg, program_store_erase_enable_next, flash_software_write_enable_reg, flash_software_write_enable_next;
  int unsigned len_reg, len_next;
  logic        hit, act;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the enables, taken only at completed APB writes
  assign hit = psel_i && penable_i && pready_o && pwrite_i;
  assign act = cpu_wr_i && !cpu_stall_o;
  always_comb begin
    program_store_write_enable_next = program_store_write_enable_reg;
    program_store_erase_enable_next = program_store_erase_enable_reg;
    flash_software_write_enable_next = flash_software_write_enable_reg;
    len_next  = cpu_stall_o ? len_reg + 1 : 0;
    if (hit && paddr_i == OFS_PS_CTRL) begin
      program_store_write_enable_next = pwdata_i[PS_WRITE_EN_BIT];
      program_store_erase_enable_next = pwdata_i[PS_ERASE_EN_BIT];
    end
    if (hit && paddr_i == OFS_FLASH_CTRL) begin
      flash_software_write_enable_next = pwdata_i[FL_SW_WRITE_EN_BIT];
    end
  end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      program_store_write_enable_reg <= 1'b0;
      program_store_erase_enable_reg <= 1'b0;
      flash_software_write_enable_reg <= 1'b0;
      len_reg  <= 0;
    end else begin
      program_store_write_enable_reg <= program_store_write_enable_next;
      program_store_erase_enable_reg <= program_store_erase_enable_next;
      flash_software_write_enable_reg <= flash_software_write_enable_next;
      len_reg  <= len_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_irq_hold: assert property (irq_hold_o == cpu_stall_o)
    else $error("interrupt hold differs from stall");
  a_ram_read: assert property (cpu_rd_i |=> external_data_ram_re_o)
    else $error("data read not sent to external RAM");
  a_ram_write: assert property (act && !program_store_write_enable_reg |=> external_data_ram_we_o)
    else $error("data write not sent to external RAM");
  a_flash_redirect: assert property (act && program_store_write_enable_reg |=> !external_data_ram_we_o)
    else $error("redirected write reached external RAM");
  a_sw_refuse: assert property (act && program_store_write_enable_reg && !flash_software_write_enable_reg |=> !cpu_stall_o)
    else $error("flash operation without software enable");
  a_prog_start: assert property (act && program_store_write_enable_reg && flash_software_write_enable_reg && !program_store_erase_enable_reg
    && cpu_addr_i < RESERVED_BASE |=> cpu_stall_o)
    else $error("byte program did not start");
  a_erase_start: assert property (act && program_store_write_enable_reg && flash_software_write_enable_reg && program_store_erase_enable_reg
    && cpu_addr_i < 16'hfc00 |=> cpu_stall_o)
    else $error("page erase did not start");
  a_lock_page: assert property (act && program_store_write_enable_reg && flash_software_write_enable_reg && program_store_erase_enable_reg
    && cpu_addr_i[15:9] == LOCK_PAGE |=> !cpu_stall_o)
    else $error("lock page erased by software");
  a_stall_len: assert property ($fell(cpu_stall_o)
    |-> (len_reg == WRITE_CYCLES || len_reg == ERASE_CYCLES))
    else $error("stall length wrong");
  a_deny_zero: assert property (jtag_done_o && jtag_denied_o && jtag_op_i == JOP_READ
    |-> jtag_rdata_o == DENIED_BYTE)
    else $error("denied port read leaked data");
endmodule : fpe_flash_ctrl_asserts
bind fpe_flash_ctrl fpe_flash_ctrl_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) i_fpe_asserts (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_addr_i(cpu_addr_i),
  .cpu_stall_o(cpu_stall_o), .irq_hold_o(irq_hold_o),
  .external_data_ram_we_o(external_data_ram_we_o),
  .external_data_ram_re_o(external_data_ram_re_o), .jtag_done_o(jtag_done_o),
  .jtag_op_i(jtag_op_i), .jtag_denied_o(jtag_denied_o), .jtag_rdata_o(jtag_rdata_o));
`default_nettype wire

// File: dv/fpe_cpu_model.sv
// Core-side model issuing data-space writes and reads.
// Assumes the sequencer clock and a stall output that is registered.
`timescale 1ns/1ps
`default_nettype none
module fpe_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [15:0] addr_o,
  output var  logic [7:0]  wdata_o
);
  // Interrupts are never taken here, as if masked around updates
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 16'h5a5a;
    wdata_o = 8'ha5;
  end
  // Waits for a free core, since a write during a stall is lost
  task automatic issue(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    while (stall_i && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    wr_o    <= w;
    rd_o    <= !w;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    // Released lines flip so a stale value is never taken for a live one
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : issue
endmodule : fpe_cpu_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the flash sequencer.
// Assumes fpe_pkg offsets; erase time shortened to 600 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpe_pkg::*;
  localparam int unsigned EC = 600;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  pa = 8'h00, rb[6], jwd = 8'h00, crd, jrd, jdl, rwd;
  logic [31:0] pwd = 32'h0, prdata, r;
  logic [15:0] ca = 16'h0, ja = 16'h0, caddr, raddr;
  logic [1:0]  jop = 2'h0;
  logic        cf = 1'b0, cv = 1'b0, cvq = 1'b0, jreq = 1'b0, cwr, crdq, stall;
  logic        pready, pslverr, irqh, rwe, rre, jd, jden;
  logic [7:0]  cwd;
  logic [32:0] aq[$];
  logic [7:0]  cq[$];
  logic [9:0]  jq[$];
  logic [23:0] rq[$];
  int          num_errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  fpe_flash_ctrl #(.ERASE_CYCLES(EC)) i_fpe_flash_ctrl (.sys_clk_i(clk), .reset_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .cpu_wr_i(cwr),
    .cpu_rd_i(crdq), .cpu_addr_i(caddr), .cpu_wdata_i(cwd), .cpu_stall_o(stall),
    .irq_hold_o(irqh), .external_data_ram_we_o(rwe), .external_data_ram_re_o(rre),
    .external_data_ram_addr_o(raddr), .external_data_ram_wdata_o(rwd),
    .code_addr_i(ca), .code_fetch_i(cf), .code_rdata_o(crd), .jtag_req_i(jreq),
    .jtag_op_i(jop), .jtag_addr_i(ja), .jtag_wdata_i(jwd), .jtag_done_o(jd),
    .jtag_denied_o(jden), .jtag_rdata_o(jrd), .jtag_debug_lock_o(jdl));
  fpe_cpu_model i_fpe_cpu_model (.clk_i(clk), .stall_i(stall), .wr_o(cwr), .rd_o(crdq),
    .addr_o(caddr), .wdata_o(cwd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string k, input logic [39:0] g, input logic [39:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, k, g, e);
    end
  endtask : cmp
  always @(posedge clk) cvq <= cv;
  // Results are matched against the oldest note once they have settled
  always @(negedge clk) begin
    logic [9:0] e;
    if (pready !== 1'b0) cmp("apb", 40'({pslverr, prdata}), aq.size() ? 40'(aq.pop_front()) : 'x);
    if (cvq) cmp("code", 40'(crd), cq.size() ? 40'(cq.pop_front()) : 'x);
    if (rwe !== 1'b0) cmp("ram", 40'({raddr, rwd}), rq.size() ? 40'(rq.pop_front()) : 'x);
    if (jd !== 1'b0) begin
      e = jq.size() ? jq.pop_front() : 'x;
      cmp("jtag", 40'({jden, e[9] ? jrd : e[7:0]}), 40'(e[8:0]));
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    aq.push_back(e);
    @(posedge clk);
    pen <= 1'b1;
    @(negedge clk);
    while (!pready) begin
      @(negedge clk);
    end
    @(posedge clk);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  task automatic cw(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    i_fpe_cpu_model.issue(1'b1, a, d);
    repeat (2) @(negedge clk);
    while (stall && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask : cw
  task automatic cr(input logic [15:0] a, input logic f, input logic [7:0] e);
    @(posedge clk);
    ca <= a;
    cf <= f;
    cv <= 1'b1;
    cq.push_back(e);
    @(posedge clk);
    cv <= 1'b0;
  endtask : cr
  task automatic jt(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                    input logic [9:0] e);
    int n;
    n = 0;
    @(posedge clk);
    jreq <= 1'b1;
    jop  <= op;
    ja   <= a;
    jwd  <= d;
    jq.push_back(e);
    @(negedge clk);
    while (!jd && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    jreq <= 1'b0;
    ja   <= ~a;
    jwd  <= ~d;
  endtask : jt
  task automatic final_report;
    num_errors += aq.size() + cq.size() + jq.size() + rq.size();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // Run is near 5.4k cycles; the limit leaves over seven times that
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(32'ha35b60bb);
    foreach (rb[i]) rb[i] = 8'($urandom());
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_PS_CTRL, 32'(PS_CTRL_RESET));
    rd(OFS_FLASH_CTRL, 32'(FL_CTRL_RESET));
    rd(OFS_STATUS, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
    rq.push_back({16'h0321, rb[0]});
    cw(16'h0321, rb[0]);
    wr(OFS_PS_CTRL, 32'h1);
    i_fpe_cpu_model.issue(1'b0, 16'h0055, 8'h00);
    cw(16'h1234, rb[1]);
    rd(OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_FLASH_CTRL, 32'h81);
    cw(16'h1234, rb[1]);
    cr(16'h1234, 1'b0, rb[1]);
    cw(16'h1234, rb[2]);
    cr(16'h1234, 1'b0, rb[1] & rb[2]);
    cw(16'h11ff, rb[3]);
    cw(16'h1400, rb[4]);
    rd(OFS_PS_CTRL, 32'h1);
    wr(OFS_PS_CTRL, 32'h3);
    cw(16'h1300, 8'h00);
    cr(16'h1200, 1'b0, ERASED_BYTE);
    cr(16'h1234, 1'b0, ERASED_BYTE);
    cr(16'h13ff, 1'b0, ERASED_BYTE);
    cr(16'h11ff, 1'b0, rb[3]);
    cr(16'h1400, 1'b0, rb[4]);
    cw(16'hfd10, 8'h00);
    rd(OFS_STATUS, 32'h2);
    wr(OFS_PS_CTRL, 32'h7);
    cw(16'h0010, 8'h00);
    wr(OFS_PS_CTRL, 32'h5);
    cw(16'h0010, rb[5]);
    cr(16'h0010, 1'b0, rb[5]);
    cr(16'h0010, 1'b1, ERASED_BYTE);
    wr(OFS_PS_CTRL, 32'h1);
    cr(16'h0010, 1'b0, ERASED_BYTE);
    cw(READ_LOCK_ADDR, 8'hfe);
    cr(READ_LOCK_ADDR, 1'b0, 8'hfe);
    wr(OFS_PS_CTRL, 32'h0);
    wr(OFS_FLASH_CTRL, 32'h80);
    jt(JOP_WRITE, WRITE_LOCK_ADDR, 8'hfd, 10'h0);
    jt(JOP_READ, 16'h0010, 8'h00, 10'h300);
    jt(JOP_READ, 16'h2010, 8'h00, {2'b10, ERASED_BYTE});
    jt(JOP_READ, WRITE_LOCK_ADDR, 8'h00, {2'b10, 8'hfd});
    jt(JOP_WRITE, 16'h2010, 8'h00, 10'h100);
    jt(JOP_ERASE, 16'h2000, 8'h00, 10'h100);
    jt(JOP_WRITE, 16'h4010, rb[0], 10'h0);
    jt(JOP_READ, 16'h4010, 8'h00, {2'b10, rb[0]});
    jt(JOP_READ, 16'hfe10, 8'h00, 10'h300);
    jt(2'h3, 16'h4010, 8'h00, 10'h100);
    cmp("debug lock", 40'(jdl), 40'h01);
    final_report();
  end
endmodule : tb
`default_nettype wire
